// ### src/sfbx_pkg.sv
package sfbx_pkg;
  // instruction kinds presented to the unit
  typedef enum logic [2:0] {
    SFBX_OP_NONE = 3'h0,
    SFBX_OP_SKIP_REG_BIT_CLEAR = 3'h1,
    SFBX_OP_SKIP_REG_BIT_SET = 3'h2,
    SFBX_OP_SKIP_IO_BIT_CLEAR = 3'h3,
    SFBX_OP_SKIP_IO_BIT_SET = 3'h4,
    SFBX_OP_BRANCH_FLAG_SET = 3'h5,
    SFBX_OP_BRANCH_FLAG_CLEAR = 3'h6
  } sfbx_op_e;

  typedef enum logic [1:0] {
    SFBX_ST_IDLE = 2'h0,
    SFBX_ST_WAIT1 = 2'h1,
    SFBX_ST_WAIT2 = 2'h2
  } sfbx_state_e;

  localparam int SFBX_PC_W = 22;
  localparam logic [21:0] SFBX_PC_RESET = 22'h000000;
  localparam logic [21:0] SFBX_STEP_ONE = 22'h000001;
  localparam logic [21:0] SFBX_STEP_SKIP1 = 22'h000002;
  localparam logic [21:0] SFBX_STEP_SKIP2 = 22'h000003;
  localparam logic [1:0] SFBX_EXTRA_NONE = 2'h0;
  localparam logic [1:0] SFBX_EXTRA_ONE = 2'h1;
  localparam logic [1:0] SFBX_EXTRA_TWO = 2'h2;
  localparam logic [7:0] SFBX_FLAGS_RESET = 8'h00;
endpackage

// ### src/sfbx_cond.sv
`timescale 1ns/1ps
`default_nettype none
// combinational condition test: picks one bit and compares it
module sfbx_cond
  import sfbx_pkg::*;
(
  // operand
  input wire logic [7:0] value_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic want_set_in,
  // result
  output logic hit_out
);
  always_comb begin
    hit_out = (value_in[bit_sel_in] == want_set_in);
  end
endmodule
`default_nettype wire

// ### src/sfbx_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - io bit clear skips next instruction
// - io bit set skips next instruction
// - flag set branches to pc plus k plus one
// - flag clear branches to pc plus k plus one
module sfbx_exec
  import sfbx_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // instruction issue
  input wire logic issue_in,
  input wire logic [2:0] op_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [6:0] offset_k_in,
  input wire logic next_is_two_word_in,
  input wire logic [21:0] pc_in,
  // operands
  input wire logic [7:0] source_work_reg_in,
  input wire logic [7:0] io_reg_in,
  input wire logic [7:0] status_flags_in,
  // results
  output logic busy_out,
  output logic done_out,
  output logic pc_load_out,
  output logic [21:0] pc_new_out,
  output logic taken_out,
  output logic [7:0] status_flags_out
);
  // ----------------------------------------------------------------
  // condition select
  // ----------------------------------------------------------------
  logic [7:0] operand;
  logic want_set;
  logic is_skip;
  logic is_branch;
  logic hit;

  always_comb begin
    operand = source_work_reg_in;
    want_set = 1'b0;
    is_skip = 1'b0;
    is_branch = 1'b0;
    unique case (op_in)
      SFBX_OP_SKIP_REG_BIT_CLEAR: begin
        is_skip = 1'b1;
      end
      SFBX_OP_SKIP_REG_BIT_SET: begin
        is_skip = 1'b1;
        want_set = 1'b1;
      end
      SFBX_OP_SKIP_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        operand = io_reg_in;
      end
      SFBX_OP_SKIP_IO_BIT_SET: begin
        is_skip = 1'b1;
        operand = io_reg_in;
        want_set = 1'b1;
      end
      SFBX_OP_BRANCH_FLAG_SET: begin
        is_branch = 1'b1;
        operand = status_flags_in;
        want_set = 1'b1;
      end
      SFBX_OP_BRANCH_FLAG_CLEAR: begin
        is_branch = 1'b1;
        operand = status_flags_in;
      end
      default: begin
        // unused op codes execute as nothing
      end
    endcase
  end

  sfbx_cond u_cond (
    .value_in(operand),
    .bit_sel_in(bit_sel_in),
    .want_set_in(want_set),
    .hit_out(hit)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  sfbx_state_e state, next_state;
  logic [21:0] pc_hold, next_pc_hold;
  logic [21:0] offset_ext;
  logic [21:0] target;
  logic accept;

  // a request while busy, or with an unused op code, is dropped without any
  // sign at the ports; the issuing side waits for done before the next one
  assign accept = issue_in && (state == SFBX_ST_IDLE) && (is_skip || is_branch);
  // k is a signed word offset, sign-extended to the counter width
  assign offset_ext = {{15{offset_k_in[6]}}, offset_k_in};

  // skips and taken branches park their target in pc_hold; a skip over a
  // two-word instruction passes through WAIT1 for its second cycle
  always_comb begin
    next_state = state;
    next_pc_hold = pc_hold;
    target = pc_in + SFBX_STEP_ONE;
    if (accept && hit) begin
      if (is_branch) begin
        target = pc_in + offset_ext + SFBX_STEP_ONE;
        next_state = SFBX_ST_WAIT2;
      end else if (next_is_two_word_in) begin
        target = pc_in + SFBX_STEP_SKIP2;
        next_state = SFBX_ST_WAIT1;
      end else begin
        target = pc_in + SFBX_STEP_SKIP1;
        next_state = SFBX_ST_WAIT2;
      end
    end
    if (accept) begin
      next_pc_hold = target;
    end
    unique case (state)
      SFBX_ST_IDLE: begin
      end
      SFBX_ST_WAIT1: begin
        next_state = SFBX_ST_WAIT2;
      end
      SFBX_ST_WAIT2: begin
        next_state = SFBX_ST_IDLE;
      end
      default: begin
        // an upset state code falls back to idle rather than locking up
        next_state = SFBX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= SFBX_ST_IDLE;
      pc_hold <= SFBX_PC_RESET;
    end else begin
      state <= next_state;
      pc_hold <= next_pc_hold;
    end
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  logic done, next_done;
  logic pc_load, next_pc_load;
  logic taken, next_taken;
  logic [21:0] pc_new, next_pc_new;

  // the new pc is published in the last cycle of the instruction so the
  // fetch side sees one load per instruction whatever its length
  always_comb begin
    next_done = 1'b0;
    next_pc_load = 1'b0;
    next_taken = taken;
    next_pc_new = pc_new;
    if (accept) begin
      next_taken = hit;
      if (!hit) begin
        next_done = 1'b1;
        next_pc_load = 1'b1;
        next_pc_new = target;
      end
    end else if (state == SFBX_ST_WAIT2) begin
      next_done = 1'b1;
      next_pc_load = 1'b1;
      next_pc_new = pc_hold;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done <= 1'b0;
      pc_load <= 1'b0;
      taken <= 1'b0;
      pc_new <= SFBX_PC_RESET;
    end else begin
      done <= next_done;
      pc_load <= next_pc_load;
      taken <= next_taken;
      pc_new <= next_pc_new;
    end
  end

  // ----------------------------------------------------------------
  // flag copy
  // ----------------------------------------------------------------
  logic [7:0] flags_kept, next_flags_kept;

  // none of these instructions writes a flag; the copy is registered so the
  // flags leave the unit from a flip-flop like every other result except busy_out, which is decoded from state
  always_comb begin
    next_flags_kept = status_flags_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_kept <= SFBX_FLAGS_RESET;
    end else begin
      flags_kept <= next_flags_kept;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy_out = (state != SFBX_ST_IDLE);
  assign done_out = done;
  assign pc_load_out = pc_load;
  assign pc_new_out = pc_new;
  assign taken_out = taken;
  assign status_flags_out = flags_kept;
endmodule
`default_nettype wire

// ### verif/sfbx_exec_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sfbx_exec_sva
  import sfbx_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // instruction issue
  input wire logic issue_in,
  input wire logic [2:0] op_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [6:0] offset_k_in,
  input wire logic next_is_two_word_in,
  input wire logic [21:0] pc_in,
  // operands
  input wire logic [7:0] source_work_reg_in,
  input wire logic [7:0] io_reg_in,
  input wire logic [7:0] status_flags_in,
  // results
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic pc_load_out,
  input wire logic [21:0] pc_new_out,
  input wire logic taken_out,
  input wire logic [7:0] status_flags_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [7:0] v;
  logic hit, acc;
  logic [21:0] tgt;
  // --------
  // decode of the accepted request
  // --------
  assign v = op_in < 3'h3 ? source_work_reg_in : op_in < 3'h5 ? io_reg_in : status_flags_in;
  assign hit = v[bit_sel_in] == (op_in == 3'h2 || op_in == 3'h4 || op_in == 3'h5);
  assign acc = issue_in && !busy_out && op_in > 3'h0 && op_in < 3'h7;
  assign tgt = pc_in + {{15{offset_k_in[6]}}, offset_k_in} + 22'h000001;
  sequence s_wait1;
    busy_out ##1 done_out;
  endsequence
  sequence s_wait2;
    busy_out[*2] ##1 done_out;
  endsequence
  a_reg_clear_skip: assert property (acc && op_in == 3'h1 && hit && !next_is_two_word_in |=>
    s_wait1 ##0 pc_new_out == $past(pc_in, 2) + SFBX_STEP_SKIP1) else $error("reg clear skip wrong");
  a_reg_set_skip: assert property (acc && op_in == 3'h2 && hit && next_is_two_word_in |=>
    s_wait2 ##0 pc_new_out == $past(pc_in, 3) + SFBX_STEP_SKIP2) else $error("reg set skip wrong");
  a_io_clear_fail: assert property (acc && op_in == 3'h3 && !hit |=>
    done_out && pc_load_out && !taken_out && pc_new_out == $past(pc_in) + 22'h000001) else $error("io fall wrong");
  a_io_set_skip: assert property (acc && op_in == 3'h4 && hit |=> busy_out && taken_out) else $error("io skip");
  a_flag_set_jump: assert property (acc && op_in == 3'h5 && hit |=>
    s_wait1 ##0 pc_new_out == $past(tgt, 2)) else $error("flag set branch wrong");
  a_flag_clear_fall: assert property (acc && op_in == 3'h6 && !hit |=>
    done_out && pc_new_out == $past(pc_in) + 22'h000001) else $error("flag clear fall wrong");
  a_skip_cycle_count: assert property (acc && op_in < 3'h5 && hit |=>
    busy_out ##1 done_out == !$past(next_is_two_word_in, 2)) else $error("skip length wrong");
  a_flags_kept: assert property ($past(resetn_in) |->
    status_flags_out == $past(status_flags_in)) else $error("flags altered");
endmodule
bind sfbx_exec sfbx_exec_sva i_sva (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .issue_in(issue_in),
  .op_in(op_in),
  .bit_sel_in(bit_sel_in),
  .offset_k_in(offset_k_in),
  .next_is_two_word_in(next_is_two_word_in),
  .pc_in(pc_in),
  .source_work_reg_in(source_work_reg_in),
  .io_reg_in(io_reg_in),
  .status_flags_in(status_flags_in),
  .busy_out(busy_out),
  .done_out(done_out),
  .pc_load_out(pc_load_out),
  .pc_new_out(pc_new_out),
  .taken_out(taken_out),
  .status_flags_out(status_flags_out)
);
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 0, resetn_in = 0, issue_in = 0, two = 0, busy, done, ld, tk;
  logic [2:0] op = 0, bsel = 0;
  logic [6:0] k = 0;
  logic [21:0] pc = 0, pcn, e;
  logic [7:0] wr = 0, io = 0, st = 0, fo;
  int fails = 0, n_checks = 0, cyc = 0, n;
  // op, bit, operand, two-word and k, expected cycles
  logic [23:0] rows [12] = '{{3'h1,3'h3,8'hf7,8'h00,2'h2}, {3'h1,3'h0,8'h01,8'h80,2'h1},
    {3'h2,3'h7,8'h80,8'h80,2'h3}, {3'h2,3'h7,8'h7f,8'h00,2'h1}, {3'h3,3'h5,8'hdf,8'h80,2'h3},
    {3'h3,3'h5,8'h20,8'h00,2'h1}, {3'h4,3'h2,8'h04,8'h00,2'h2}, {3'h4,3'h2,8'hfb,8'h80,2'h1},
    {3'h5,3'h1,8'h02,8'h40,2'h2}, {3'h5,3'h1,8'hfd,8'h40,2'h1}, {3'h6,3'h6,8'hbf,8'h3f,2'h2},
    {3'h6,3'h6,8'h40,8'h3f,2'h1}};
  sfbx_exec i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .issue_in(issue_in), .op_in(op),
    .bit_sel_in(bsel), .offset_k_in(k), .next_is_two_word_in(two), .pc_in(pc),
    .source_work_reg_in(wr), .io_reg_in(io), .status_flags_in(st), .busy_out(busy), .done_out(done),
    .pc_load_out(ld), .pc_new_out(pcn), .taken_out(tk), .status_flags_out(fo));
  task automatic chk(input logic [25:0] s, input logic [25:0] x, input string nm);
    n_checks++;
    if (s !== x) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, x, s);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // --------
  // one instruction; hold keeps a second request up while busy
  // --------
  task automatic run(input logic [23:0] r, input logic hold);
    logic [7:0] v;
    {op, bsel, v, two, k} = r[23:2];
    wr = op < 3'h3 ? v : ~v;
    io = (op == 3'h3 || op == 3'h4) ? v : ~v;
    st = op > 3'h4 ? v : ~v;
    pc = pc + 22'h000011;
    issue_in = 1;
    // the edge that takes the request counts as the first cycle
    @(posedge clk_in);
    #1;
    n = 1;
    if (!done) begin
      issue_in = hold;
      op = hold ? 3'h4 : op;
    end
    while (!done && n < 5) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    e = r[1:0] == 2'h1 ? pc + 22'h000001 : op > 3'h4 ? pc + {{15{k[6]}}, k} + 22'h000001 : pc + 22'(r[1:0]);
    chk(26'(n), 26'(r[1:0]), "cycles");
    chk(26'({ld, pcn}), 26'({1'b1, e}), "pc");
    chk(26'(tk), 26'(r[1:0] > 2'h1), "taken");
    chk(26'(fo), 26'(st), "flags");
    chk(26'(busy), 26'h0, "busy at done");
  endtask
  initial forever #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    #1;
    resetn_in = 1;
    chk({busy, done, ld, tk, pcn}, 26'h0, "reset");
    // unused op codes 7 and then 0 must stay silent
    op = 3'h7;
    issue_in = 1;
    repeat (3) begin
      @(posedge clk_in);
      #1;
      chk(26'({busy, done, ld}), 26'h0, "ignored op");
      if (op == 3'h7) op = 3'h0;
    end
    foreach (rows[i]) run(rows[i], 1'b0);
    run({3'h2,3'h0,8'h01,8'h80,2'h3}, 1'b1);
    // reset in the middle of a long skip drops it, then work resumes
    {op, bsel, wr, two} = {3'h2, 3'h0, 8'h01, 1'b1};
    @(posedge clk_in);
    #1;
    issue_in = 0;
    resetn_in = 0;
    #1;
    chk({busy, done, ld, tk, pcn}, 26'h0, "mid reset");
    chk(26'(fo), 26'h0, "mid reset flags");
    @(posedge clk_in);
    #1;
    resetn_in = 1;
    run(rows[0], 1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
